// [logic/sas_defines.svh]
// Register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SAS_IDX_RESULT    8'hbe
`define SAS_IDX_CONTROL   8'he8
`define SAS_IDX_GT        8'hc0
`define SAS_IDX_LT        8'hc1
`define SAS_IDX_CONFIG    8'hc2

// ****************************************************************
// Control register fields
// ****************************************************************
`define SAS_CTL_EN        7
`define SAS_CTL_TM        6
`define SAS_CTL_DONE      5
`define SAS_CTL_BUSY      4
`define SAS_CTL_MODE_HI   3
`define SAS_CTL_MODE_LO   1
`define SAS_CTL_WINT      0

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define SAS_CFG_DIV_HI    4
`define SAS_CFG_DIV_LO    0
`define SAS_CFG_DIFF      5
`define SAS_CFG_OWN_EN    6
`define SAS_CFG_SIB_EN    7

// ****************************************************************
// Reset values
// ****************************************************************
`define SAS_RST_RESULT    8'h00
`define SAS_RST_CONTROL   8'h00
`define SAS_RST_GT        8'hff
`define SAS_RST_LT        8'h00
`define SAS_RST_CONFIG    8'h1f

// ****************************************************************
// Start modes and timing counts in converter clocks
// ****************************************************************
`define SAS_MODE_SW       3'h0
`define SAS_MODE_T3       3'h1
`define SAS_MODE_EXT      3'h2
`define SAS_MODE_T2       3'h3
`define SAS_TRACK_TICKS   4'h3
`define SAS_CONV_TICKS    4'h8

// ****************************************************************
// Bus answers
// ****************************************************************
`define SAS_RESP_OKAY     2'h0
`define SAS_RESP_DECERR   2'h3

`endif

// [logic/sas_pkg.sv]
// Types shared by the converter sequencer
`default_nettype none

package sas_pkg;

    typedef enum logic [1:0] {
        SAS_IDLE,
        SAS_TRACK,
        SAS_CONVERT
    } sas_state_t;

    typedef enum logic [2:0] {
        SAS_SEL_NONE,
        SAS_SEL_RESULT,
        SAS_SEL_CONTROL,
        SAS_SEL_GT,
        SAS_SEL_LT,
        SAS_SEL_CONFIG
    } sas_sel_t;

endpackage : sas_pkg

`default_nettype wire

// [logic/sas_adc_seq.sv]
// Sequencer, result and window detector of an 8-bit successive-approximation converter
// Function
// - Enable bit low holds converter shut down
// - Normal track mode tracks except while converting
// - Done flag sets when busy falls
// - Busy reads one while conversion runs
// - Busy write of one starts only mode 000
// - Start mode picks software, timers or pin
// - Modes 1xx start on sibling busy write
// - Low-power mode tracks three converter clocks first
// - Low-power pin mode tracks while pin low
// - Own pin if enabled, else sibling pin; the sibling pin needs its own enable bit, else no pin starts
// - Eight-bit result register, reset zero
// - Single-ended results compared unsigned
// - Differential results compared two's complement
// - Every result compared against both limits
// - Greater below less flags strictly inside
// - Limit order selects inside or outside
// - Window flag sticks until software clears
// - Conversion lasts at least eight converter clocks
// - Converter clock is system clock over divider+1
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defines.svh"

module sas_adc_seq
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Trigger sources
    input  wire logic        timer3_overflow,
    input  wire logic        timer2_overflow,
    input  wire logic        sibling_busy_bit,
    input  wire logic        own_convert_start_pin,
    input  wire logic        sibling_convert_start_pin,
    // Analog core
    input  wire logic        core_compare,
    output logic             core_enable,
    output logic             core_track,
    output logic             core_convert,
    output logic [7:0]       core_trial_code,
    output logic             converter_clock,
    output logic             conversion_busy
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]  result_reg;
    logic [7:0]  gt_reg;
    logic [7:0]  lt_reg;
    logic [7:0]  cfg_reg;
    logic        enable_reg;
    logic        track_mode_reg;
    logic        done_reg;
    logic [2:0]  mode_reg;
    logic        wint_reg;
    sas_state_t  state_reg;
    logic [4:0]  tick_cnt_reg;
    logic [3:0]  step_reg;
    logic [7:0]  sar_reg;
    logic [7:0]  sar_next;
    logic        track_reg;
    logic        own_s1_reg;
    logic        own_s2_reg;
    logic        sib_s1_reg;
    logic        sib_s2_reg;
    logic        cmp_s1_reg;
    logic        cmp_s2_reg;
    logic        ext_prev_reg;
    logic        aw_hold_reg;
    logic [11:0] awaddr_reg;
    logic        w_hold_reg;
    logic [7:0]  wdata_reg;
    logic        wstrb0_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [7:0]  rdata_reg;
    logic [1:0]  rresp_reg;
    logic        wr_fire;
    logic        wr_en;
    sas_sel_t    wr_sel;
    sas_sel_t    rd_sel;
    logic        sw_start;
    logic        ext_level;
    logic        ext_rise;
    logic        trigger;
    logic        start;
    logic        tick;
    logic        last_step;
    logic [2:0]  bit_idx;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic sas_sel_t decode(input logic [11:0] addr);
        sas_sel_t sel;
        sel = SAS_SEL_NONE;
        if (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) begin
            unique case (addr[9:2])
                `SAS_IDX_RESULT:  sel = SAS_SEL_RESULT;
                `SAS_IDX_CONTROL: sel = SAS_SEL_CONTROL;
                `SAS_IDX_GT:      sel = SAS_SEL_GT;
                `SAS_IDX_LT:      sel = SAS_SEL_LT;
                `SAS_IDX_CONFIG:  sel = SAS_SEL_CONFIG;
                default:          sel = SAS_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode

    function automatic logic signed [8:0] widen(input logic [7:0] v, input logic diff);
        return diff ? {v[7], v} : {1'b0, v};
    endfunction : widen

    function automatic logic in_window(input logic [7:0] res, input logic [7:0] gt,
                                       input logic [7:0] lt, input logic diff);
        logic signed [8:0] r;
        logic signed [8:0] g;
        logic signed [8:0] l;
        r = widen(res, diff);
        g = widen(gt, diff);
        l = widen(lt, diff);
        if (g < l) begin
            return (r > g) && (r < l);
        end
        return (r < l) || (r > g);
    endfunction : in_window

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            own_s1_reg   <= 1'b1;
            own_s2_reg   <= 1'b1;
            sib_s1_reg   <= 1'b1;
            sib_s2_reg   <= 1'b1;
            cmp_s1_reg   <= 1'b0;
            cmp_s2_reg   <= 1'b0;
            ext_prev_reg <= 1'b1;
        end else begin
            own_s1_reg   <= own_convert_start_pin;
            own_s2_reg   <= own_s1_reg;
            sib_s1_reg   <= sibling_convert_start_pin;
            sib_s2_reg   <= sib_s1_reg;
            cmp_s1_reg   <= core_compare;
            cmp_s2_reg   <= cmp_s1_reg;
            ext_prev_reg <= ext_level;
        end
    end

    // ****************************************************************
    // Trigger selection
    // ****************************************************************
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_en   = wr_fire && wstrb0_reg;
    assign wr_sel  = decode(awaddr_reg);
    assign rd_sel  = decode(s_axi_araddr);

    assign sw_start = wr_en && wr_sel == SAS_SEL_CONTROL && wdata_reg[`SAS_CTL_BUSY]
                      && wdata_reg[`SAS_CTL_MODE_HI:`SAS_CTL_MODE_LO] == `SAS_MODE_SW;

    always_comb begin
        if (cfg_reg[`SAS_CFG_OWN_EN]) begin
            ext_level = own_s2_reg;
        end else if (cfg_reg[`SAS_CFG_SIB_EN]) begin
            ext_level = sib_s2_reg;
        end else begin
            ext_level = 1'b1;
        end
    end

    assign ext_rise = ext_level && !ext_prev_reg;

    always_comb begin
        unique case (mode_reg)
            `SAS_MODE_SW:  trigger = sw_start;
            `SAS_MODE_T3:  trigger = timer3_overflow;
            `SAS_MODE_EXT: trigger = ext_rise;
            `SAS_MODE_T2:  trigger = timer2_overflow;
            default:       trigger = sibling_busy_bit;
        endcase
    end

    assign start = enable_reg && state_reg == SAS_IDLE && (trigger || sw_start);

    // ****************************************************************
    // Converter clock divider
    // ****************************************************************
    assign tick = enable_reg && tick_cnt_reg == cfg_reg[`SAS_CFG_DIV_HI:`SAS_CFG_DIV_LO];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= 5'h00;
        end else if (!enable_reg || start || tick) begin
            tick_cnt_reg <= 5'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 5'h01;
        end
    end

    // ****************************************************************
    // Successive approximation step
    // ****************************************************************
    assign bit_idx   = 3'(4'h7 - step_reg);
    assign last_step = step_reg == (`SAS_CONV_TICKS - 4'h1);

    always_comb begin
        sar_next = sar_reg;
        sar_next[bit_idx] = cmp_s2_reg;
        if (bit_idx != 3'h0) begin
            sar_next[bit_idx - 3'h1] = 1'b1;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= SAS_IDLE;
            step_reg  <= 4'h0;
            sar_reg   <= 8'h00;
        end else if (!enable_reg) begin
            state_reg <= SAS_IDLE;
            step_reg  <= 4'h0;
        end else begin
            unique case (state_reg)
                SAS_IDLE: begin
                    if (start && track_mode_reg && mode_reg != `SAS_MODE_EXT) begin
                        state_reg <= SAS_TRACK;
                        step_reg  <= 4'h0;
                    end else if (start) begin
                        state_reg <= SAS_CONVERT;
                        step_reg  <= 4'h0;
                        sar_reg   <= 8'h80;
                    end
                end
                SAS_TRACK: begin
                    if (tick && step_reg == `SAS_TRACK_TICKS - 4'h1) begin
                        state_reg <= SAS_CONVERT;
                        step_reg  <= 4'h0;
                        sar_reg   <= 8'h80;
                    end else if (tick) begin
                        step_reg <= step_reg + 4'h1;
                    end
                end
                SAS_CONVERT: begin
                    if (tick) begin
                        sar_reg  <= sar_next;
                        step_reg <= step_reg + 4'h1;
                        if (last_step) begin
                            state_reg <= SAS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Analog core controls
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            track_reg <= 1'b0;
        end else if (!track_mode_reg) begin
            track_reg <= enable_reg && state_reg != SAS_CONVERT;
        end else begin
            track_reg <= enable_reg && (state_reg == SAS_TRACK
                         || (state_reg == SAS_IDLE && mode_reg == `SAS_MODE_EXT
                             && !ext_level));
        end
    end

    assign core_enable     = enable_reg;
    assign core_track      = track_reg;
    assign core_convert    = state_reg == SAS_CONVERT;
    assign core_trial_code = sar_reg;
    assign converter_clock = tick;
    assign conversion_busy = state_reg != SAS_IDLE;

    // ****************************************************************
    // Result, limits and configuration
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= `SAS_RST_RESULT;
        end else if (state_reg == SAS_CONVERT && tick && last_step && enable_reg) begin
            result_reg <= sar_next;
        end else if (wr_en && wr_sel == SAS_SEL_RESULT) begin
            result_reg <= wdata_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gt_reg  <= `SAS_RST_GT;
            lt_reg  <= `SAS_RST_LT;
            cfg_reg <= `SAS_RST_CONFIG;
        end else if (wr_en) begin
            if (wr_sel == SAS_SEL_GT) begin
                gt_reg <= wdata_reg;
            end
            if (wr_sel == SAS_SEL_LT) begin
                lt_reg <= wdata_reg;
            end
            if (wr_sel == SAS_SEL_CONFIG) begin
                cfg_reg <= wdata_reg;
            end
        end
    end

    // ****************************************************************
    // Control register and sticky flags
    // ****************************************************************
    logic conv_end;
    assign conv_end = state_reg == SAS_CONVERT && tick && last_step && enable_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg     <= 1'(`SAS_RST_CONTROL >> `SAS_CTL_EN);
            track_mode_reg <= 1'b0;
            mode_reg       <= 3'h0;
        end else if (wr_en && wr_sel == SAS_SEL_CONTROL) begin
            enable_reg     <= wdata_reg[`SAS_CTL_EN];
            track_mode_reg <= wdata_reg[`SAS_CTL_TM];
            mode_reg       <= wdata_reg[`SAS_CTL_MODE_HI:`SAS_CTL_MODE_LO];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_reg <= 1'b0;
        end else if (conv_end) begin
            done_reg <= 1'b1;
        end else if (wr_en && wr_sel == SAS_SEL_CONTROL) begin
            done_reg <= wdata_reg[`SAS_CTL_DONE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wint_reg <= 1'b0;
        end else if (conv_end && in_window(sar_next, gt_reg, lt_reg, cfg_reg[`SAS_CFG_DIFF])) begin
            wint_reg <= 1'b1;
        end else if (wr_en && wr_sel == SAS_SEL_CONTROL) begin
            wint_reg <= wdata_reg[`SAS_CTL_WINT];
        end
    end

    // ****************************************************************
    // AXI4-Lite write channels
    // ****************************************************************
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready  = !w_hold_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= 12'h000;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `SAS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (wr_sel == SAS_SEL_NONE) ? `SAS_RESP_DECERR : `SAS_RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels
    // ****************************************************************
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = {24'h000000, rdata_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            rresp_reg  <= `SAS_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= (rd_sel == SAS_SEL_NONE) ? `SAS_RESP_DECERR : `SAS_RESP_OKAY;
            unique case (rd_sel)
                SAS_SEL_RESULT:  rdata_reg <= result_reg;
                SAS_SEL_CONTROL: rdata_reg <= {enable_reg, track_mode_reg, done_reg,
                                               conversion_busy, mode_reg, wint_reg};
                SAS_SEL_GT:      rdata_reg <= gt_reg;
                SAS_SEL_LT:      rdata_reg <= lt_reg;
                SAS_SEL_CONFIG:  rdata_reg <= cfg_reg;
                SAS_SEL_NONE:    rdata_reg <= 8'h00;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule : sas_adc_seq

`default_nettype wire

// [verification/sas_core_model.sv]
// Behavioural analog core answering the successive-approximation trials
`timescale 1ns/1ps
`default_nettype none

module sas_core_model (
    // Clock
    input  wire logic       aclk,
    // Trial from the sequencer
    input  wire logic       core_convert,
    input  wire logic [7:0] core_trial_code,
    // Input level being converted
    input  wire logic [7:0] vin,
    // Comparator result
    output logic            core_compare
);
    logic tog_reg = 1'b0;

    // Comparator wanders while no trial runs
    always @(posedge aclk) tog_reg <= ~tog_reg;
    assign core_compare = core_convert ? (vin >= core_trial_code) : tog_reg;
endmodule : sas_core_model

`default_nettype wire

// [verification/sas_adc_seq_monitor.sv]
// Port checker of the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_adc_seq_monitor
    import sas_pkg::*;
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Analog core side
    input wire logic       core_enable,
    input wire logic       core_track,
    input wire logic       core_convert,
    input wire logic [7:0] core_trial_code,
    input wire logic       converter_clock,
    input wire logic       conversion_busy
);
    logic [3:0] cv_cnt_reg;
    logic [3:0] tk_cnt_reg;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Ticks seen while converting and while tracking under busy
    always_ff @(posedge aclk)
        if (!aresetn || !core_convert) cv_cnt_reg <= 4'h0;
        else if (converter_clock) cv_cnt_reg <= cv_cnt_reg + 4'h1;
    always_ff @(posedge aclk)
        if (!aresetn || core_convert || !conversion_busy) tk_cnt_reg <= 4'h0;
        else if (converter_clock) tk_cnt_reg <= tk_cnt_reg + 4'h1;

    a_off_quiet: assert property (!core_enable |=> !core_convert && !conversion_busy)
        else $error("Converter active while disabled");
    a_no_track: assert property (core_convert && $past(core_convert) |-> !core_track)
        else $error("Tracking during conversion");
    a_busy_fall: assert property ($fell(core_convert) |-> $fell(conversion_busy))
        else $error("Busy not falling at conversion end");
    a_conv_busy: assert property (core_convert |-> conversion_busy)
        else $error("Busy low during conversion");
    a_conv_ticks: assert property ($fell(core_convert) && core_enable |-> $past(cv_cnt_reg) == 4'h7)
        else $error("Conversion not eight converter clocks");
    a_track_ticks: assert property ($rose(core_convert) |-> tk_cnt_reg inside {4'h0, 4'h3})
        else $error("Track phase not three converter clocks");
    a_clk_pulse: assert property (converter_clock |=> !converter_clock)
        else $error("Converter clock pulse too long");
    a_trial_msb: assert property ($rose(core_convert) |-> core_trial_code == 8'h80)
        else $error("First trial code wrong");
endmodule : sas_adc_seq_monitor

bind sas_adc_seq sas_adc_seq_monitor u_mon (.*);

`default_nettype wire

// [verification/sas_adc_seq_test.sv]
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_adc_seq_test import sas_pkg::*;;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        timer3_overflow = 1'b0;
    logic        timer2_overflow = 1'b0;
    logic        sibling_busy_bit = 1'b0;
    logic        own_convert_start_pin = 1'b1;
    logic        sibling_convert_start_pin = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rv, r;
    logic        core_compare, core_enable, core_track, core_convert, converter_clock;
    logic        conversion_busy, d, tm;
    logic [7:0]  core_trial_code, vin, gt, lt, ctl;
    logic [2:0]  mm;
    logic [7:0]  idx [5] = '{8'hbe, 8'he8, 8'hc0, 8'hc1, 8'hc2};
    logic [7:0]  rst [5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h1f};
    int          failures = 0, tests_run = 0, seed = 43;

    sas_adc_seq uut (.*);
    sas_core_model model (.*);

    initial forever #12.5 aclk = ~aclk;

    function automatic logic win(logic [7:0] rs, logic [7:0] g, logic [7:0] l, logic df);
        logic [7:0] m;
        m = {df, 7'h0};
        if ((g ^ m) < (l ^ m)) return ((g ^ m) < (rs ^ m)) && ((rs ^ m) < (l ^ m));
        return ((rs ^ m) < (l ^ m)) || ((rs ^ m) > (g ^ m));
    endfunction : win

    task chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, a, 2'b00};
        s_axi_wdata <= {24'h0, dv};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= {2'b00, a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task pulse(input int k, input logic trk);
        @(posedge aclk);
        case (k)
            0: timer3_overflow <= 1'b1;
            1: own_convert_start_pin <= 1'b0;
            2: timer2_overflow <= 1'b1;
            3: sibling_busy_bit <= 1'b1;
            default: sibling_convert_start_pin <= 1'b0;
        endcase
        @(posedge aclk);
        timer3_overflow <= 1'b0;
        timer2_overflow <= 1'b0;
        sibling_busy_bit <= 1'b0;
        repeat (6) @(posedge aclk);
        if (trk) chk(34'(core_track), 34'h1);
        own_convert_start_pin <= 1'b1;
        sibling_convert_start_pin <= 1'b1;
    endtask : pulse

    task wait_end;
        while (conversion_busy !== 1'b1) @(posedge aclk);
        while (conversion_busy === 1'b1) @(posedge aclk);
    endtask : wait_end

    task complete_run;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial begin
        #1000000;
        failures++;
        complete_run;
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (idx[i]) begin
            rd(idx[i]);
            chk({rr, rv}, {26'h0, rst[i]});
        end
        rd(8'h10);
        chk({rr, rv}, 34'h300000000);
        wr(8'h10, 8'h00);
        chk(34'(rr), 34'h3);
        wr(8'he8, 8'h10);
        chk(34'(rr), 34'h0);
        repeat (8) @(posedge aclk);
        chk(34'({core_enable, conversion_busy, core_track}), 34'h0);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            {tm, d, vin, lt, gt} = r[25:0];
            if (i < 4) begin
                gt = i[1] ? 8'h20 : 8'h10;
                lt = i[1] ? 8'h10 : 8'h20;
                vin = i[0] ? 8'h15 : 8'h20;
                d = 1'b0;
            end
            wr(8'hc0, gt);
            wr(8'hc1, lt);
            wr(8'hc2, {2'b01, d, 5'h02});
            ctl = {1'b1, tm, 6'h0};
            wr(8'he8, ctl);
            rd(8'he8);
            chk(34'(rv), 34'(ctl));
            if (!tm) chk(34'(core_track), 34'h1);
            wr(8'he8, ctl | 8'h10);
            wait_end;
            rd(8'hbe);
            chk(34'(rv), 34'(vin));
            rd(8'he8);
            chk(34'(rv), 34'(ctl | 8'h20 | 8'(win(vin, gt, lt, d))));
        end
        for (int k = 0; k < 5; k++) begin
            mm = (k == 4) ? 3'h2 : 3'(k + 1);
            wr(8'hc2, (k == 4) ? 8'h82 : 8'h42);
            ctl = {4'hc, mm, 1'b0};
            wr(8'he8, ctl | 8'h10);
            for (int j = 0; j < 5; j++)
                if (j != k) pulse(j, 1'b0);
            repeat (6) @(posedge aclk);
            rd(8'he8);
            chk(34'(rv), 34'(ctl));
            pulse(k, k == 1 || k == 4);
            wait_end;
            rd(8'he8);
            chk(34'(rv), 34'(ctl | 8'h20 | 8'(win(vin, gt, lt, 1'b0))));
        end
        complete_run;
    end
endmodule : sas_adc_seq_test

`default_nettype wire
